// File: core/dasr_consts.svh
// constants of the dual converter serial readout: frame layout and link timing
// assumes a 40 MHz system clock on the host end
`ifndef DASR_CONSTS_SVH
`define DASR_CONSTS_SVH
`define DASR_RESULT_BITS    12
`define DASR_NULL_BITS      4
`define DASR_HALF_BITS      16
`define DASR_FRAME_BITS     32
`define DASR_LAST_BIT       5'h1f
`define DASR_SIGN_FLIP      12'h800
`define DASR_CLK_KHZ        40000
`define DASR_SCLK_KHZ       5000
`define DASR_SCLK_MIN_KHZ   1600
`define DASR_SCLK_MAX_KHZ   6400
`define DASR_RATE_KSPS      100
`define DASR_RATE_MIN_KSPS  50
`define DASR_RATE_MAX_KSPS  200
`define DASR_SCLK_HALF_CYC  ((`DASR_CLK_KHZ + 2 * `DASR_SCLK_KHZ - 1) / (2 * `DASR_SCLK_KHZ))
`define DASR_HALF_MIN_CYC   ((`DASR_CLK_KHZ + 2 * `DASR_SCLK_MAX_KHZ - 1) / (2 * `DASR_SCLK_MAX_KHZ))
`define DASR_HALF_MAX_CYC   (`DASR_CLK_KHZ / (2 * `DASR_SCLK_MIN_KHZ))
`define DASR_PERIOD_CYC     (`DASR_CLK_KHZ / `DASR_RATE_KSPS)
`define DASR_PERIOD_MIN_CYC ((`DASR_CLK_KHZ + `DASR_RATE_MAX_KSPS - 1) / `DASR_RATE_MAX_KSPS)
`define DASR_PERIOD_MAX_CYC (`DASR_CLK_KHZ / `DASR_RATE_MIN_KSPS)
`endif

// File: core/dasr_pkg.sv
// types shared by both ends of the dual converter serial readout
// assumes dasr_consts.svh is on the include path
`include "dasr_consts.svh"
package dasr_pkg;
  typedef enum logic [1:0] {
    DEV_POWERDOWN = 2'b00,
    DEV_CONVERT   = 2'b01,
    DEV_DONE      = 2'b10
  } dasr_dev_state_t;

  typedef enum logic {
    HOST_IDLE  = 1'b0,
    HOST_FRAME = 1'b1
  } dasr_host_state_t;

  typedef logic [`DASR_RESULT_BITS-1:0] dasr_word_t;
endpackage

// File: core/dasr_link_if.sv
// serial link between the converter end and the host end
// assumes the host makes the serial clock and the select
`timescale 1ns/100ps
interface dasr_link_if;
  logic sclk;
  logic csN;
  logic sdo;

  modport device_end (
    input  sclk,
    input  csN,
    output sdo
  );

  modport host_end (
    output sclk,
    output csN,
    input  sdo
  );
endinterface

// File: core/dasr_device.sv
// converter end: simultaneous sample of two channels, bit-serial
// successive approximation stepped by the serial clock, one serial output
// assumes the host launches the select on a rising serial clock edge,
// so the select is stable at every falling edge this end acts on
// the result and abort outputs are for observation only; the link
// itself needs none of them
`timescale 1ns/100ps
`include "dasr_consts.svh"

// What this block does
// [RULE_01] both channels captured at one instant
// [RULE_02] select falling edge starts new conversion
// [RULE_03] select low keeps converting on serial clock
// [RULE_04] select high means power-down, no activity
// [RULE_05] serial clock paces bits and steps approximation
// [RULE_06] frame: 4 null, first, 4 null, second
// [RULE_07] output changes on falling, host samples rising
// [RULE_08] results in two's-complement coding
// [RULE_09] one clock and select serve both channels
// [RULE_10] host serial clock between 1.6 and 6.4 MHz
// [RULE_11] host frame rate 50 to 200 kSPS; frames can lie 816 cycles apart here, 49 kSPS
// [RULE_12] host holds select low 32 clocks
module dasr_device
  import dasr_pkg::*;
(
  dasr_link_if.device_end link,
  input  wire logic [11:0] firstChannelPosIn,
  input  wire logic [11:0] firstChannelNegIn,
  input  wire logic [11:0] secondChannelPosIn,
  input  wire logic [11:0] secondChannelNegIn,
  output logic             converting,
  output dasr_word_t       firstChannelResult,
  output dasr_word_t       secondChannelResult,
  output logic             frameShort
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // anaSync1 and anaSync2 form the two-stage synchroniser for the
  // asynchronous stand-ins; only anaSync2 is read by the logic
  typedef struct packed {
    dasr_dev_state_t st;
    logic [4:0]      bitCnt;
    dasr_word_t      heldFirst;
    dasr_word_t      heldSecond;
    dasr_word_t      acc;
    logic            sdo;
    logic [47:0]     anaSync1;
    logic [47:0]     anaSync2;
    dasr_word_t      lastFirst;
    dasr_word_t      lastSecond;
    logic            shortFlag;
  } dasr_dev_reg_t;

  localparam dasr_dev_reg_t IDLE_VALUE = '{
    st:         DEV_POWERDOWN,
    bitCnt:     5'h00,
    heldFirst:  12'h000,
    heldSecond: 12'h000,
    acc:        12'h000,
    sdo:        1'b0,
    anaSync1:   48'h000000000000,
    anaSync2:   48'h000000000000,
    lastFirst:  12'h000,
    lastSecond: 12'h000,
    shortFlag:  1'b0
  };

  dasr_dev_reg_t q;
  dasr_dev_reg_t next_q;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // differential input to offset-binary code; halving keeps the
  // full -ref..+ref span inside twelve bits
  function automatic dasr_word_t to_offset(input logic [11:0] pos, input logic [11:0] neg);
    logic [12:0] diff;
    diff = {1'b0, pos} - {1'b0, neg};
    return diff[12:1] ^ `DASR_SIGN_FLIP;
  endfunction

  // true once the null bits of a half frame are behind
  function automatic logic data_slot(input logic [4:0] pos);
    return (pos[3:0] >= 4'(`DASR_NULL_BITS));
  endfunction

  // ---------------------------------------------------------------
  // per-channel view of the synchronised inputs
  // ---------------------------------------------------------------
  // both pairs come out of the same flop stage, so one falling edge
  // freezes the two channels together
  logic [1:0][11:0] chanPos;
  logic [1:0][11:0] chanNeg;
  logic [1:0][11:0] chanCode;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign chanPos[ch]  = q.anaSync2[47 - 24 * ch -: 12];
    assign chanNeg[ch]  = q.anaSync2[35 - 24 * ch -: 12];
    assign chanCode[ch] = to_offset(chanPos[ch], chanNeg[ch]); // RULE_01
  end

  logic        resultDone;
  logic        lastBit;
  logic [3:0]  slot;
  logic        inResult;
  logic [3:0]  weight;
  dasr_word_t  trial;
  dasr_word_t  held;
  logic        decide;
  logic        outBit;
  dasr_word_t  finalWord;

  // ---------------------------------------------------------------
  // one approximation step for the bit now being sent
  // ---------------------------------------------------------------
  always_comb begin
    slot      = q.bitCnt[3:0];
    inResult  = data_slot(q.bitCnt);
    weight    = 4'(`DASR_HALF_BITS - 1) - slot;
    trial     = q.acc | (12'h001 << weight);
    held      = q.bitCnt[4] ? q.heldSecond : q.heldFirst;
    decide    = inResult && (held >= trial); // RULE_05
    // offset code to two's complement: only the top bit differs
    outBit    = (weight == 4'hb) ? ~decide : decide; // RULE_08
    finalWord = (decide ? trial : q.acc) ^ `DASR_SIGN_FLIP;
    resultDone = inResult && (weight == 4'h0);
    lastBit    = (q.bitCnt == `DASR_LAST_BIT);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q          = q;
    next_q.anaSync1 = {firstChannelPosIn, firstChannelNegIn, secondChannelPosIn, secondChannelNegIn};
    next_q.anaSync2 = q.anaSync1;
    if (link.csN) begin
      // power-down: output parked low, approximation dropped
      next_q.st     = DEV_POWERDOWN; // RULE_04
      next_q.bitCnt = 5'h00;
      next_q.acc    = 12'h000;
      next_q.sdo    = 1'b0;
      if (q.st == DEV_CONVERT) begin
        // select rose before the second result was out
        next_q.shortFlag = 1'b1;
      end
    end else begin
      unique case (q.st)
        DEV_POWERDOWN: begin
          // first falling edge with select low: track-and-hold closes
          next_q.heldFirst  = chanCode[0]; // RULE_01 RULE_02
          next_q.heldSecond = chanCode[1]; // RULE_01 RULE_09
          next_q.st         = DEV_CONVERT;
          next_q.bitCnt     = 5'h01;
          next_q.acc        = 12'h000;
          next_q.sdo        = 1'b0; // RULE_06
        end
        DEV_CONVERT: begin
          next_q.sdo    = outBit; // RULE_06 RULE_07
          next_q.bitCnt = q.bitCnt + 5'h01; // RULE_03
          if (!inResult) begin
            next_q.acc = 12'h000;
          end else if (decide) begin
            next_q.acc = trial;
          end
          // a frame cut before its first result never gets here, so the previous pair stays; a later cut renews lastFirst only
          if (resultDone) begin
            if (q.bitCnt[4]) begin
              next_q.lastSecond = finalWord;
              next_q.shortFlag  = 1'b0;
            end else begin
              next_q.lastFirst  = finalWord;
            end
          end
          if (lastBit) begin
            next_q.st = DEV_DONE;
          end
        end
        DEV_DONE: begin
          // extra clocks with select still low read as zeros
          next_q.sdo = 1'b0;
        end
        default: begin
          // illegal state code, also the unknown state before any edge
          next_q = IDLE_VALUE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers, stepped by the serial clock's falling edge
  // ---------------------------------------------------------------
  // no reset pin: a falling edge with select high resets the state,
  // count, approximation and output bit only; the result outputs and
  // frameShort stay unknown until a frame writes them, so nothing should look at them before that
  always_ff @(negedge link.sclk) begin // RULE_07
    q <= next_q;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.sdo            = q.sdo;
  assign converting          = (q.st == DEV_CONVERT);
  assign firstChannelResult  = q.lastFirst;
  assign secondChannelResult = q.lastSecond;
  assign frameShort          = q.shortFlag;

endmodule // dasr_device

// File: core/dasr_host.sv
// host end: makes the serial clock by division, frames the select,
// collects both results and queues them in a two-entry buffer
// assumes the converter end changes its output on falling clock edges
`timescale 1ns/100ps
`include "dasr_consts.svh"

module dasr_host
  import dasr_pkg::*;
#(
  parameter int SCLK_HALF_CYC = `DASR_SCLK_HALF_CYC,
  parameter int PERIOD_CYC    = `DASR_PERIOD_CYC
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  dasr_link_if.host_end    link,
  input  wire logic        run,
  output logic             resultValid,
  input  wire logic        resultReady,
  output dasr_word_t       firstChannelResult,
  output dasr_word_t       secondChannelResult
);

  // ---------------------------------------------------------------
  // limits on the link rate
  // ---------------------------------------------------------------
  // out-of-range settings are clamped; starts wait for a serial clock rise, so frames can lie up to 816 cycles apart
  localparam int HALF = (SCLK_HALF_CYC < `DASR_HALF_MIN_CYC) ? `DASR_HALF_MIN_CYC :
                        (SCLK_HALF_CYC > `DASR_HALF_MAX_CYC) ? `DASR_HALF_MAX_CYC : SCLK_HALF_CYC; // RULE_10
  localparam int PMIN = (2 * HALF * (`DASR_FRAME_BITS + 2) > `DASR_PERIOD_MIN_CYC) ?
                        2 * HALF * (`DASR_FRAME_BITS + 2) : `DASR_PERIOD_MIN_CYC;
  localparam int PER  = (PERIOD_CYC < PMIN) ? PMIN :
                        (PERIOD_CYC > `DASR_PERIOD_MAX_CYC) ? `DASR_PERIOD_MAX_CYC : PERIOD_CYC; // RULE_11

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    dasr_host_state_t st;
    logic [3:0]       halfCnt;
    logic             sclk;
    logic             csN;
    logic [4:0]       bitCnt;
    logic [31:0]      shift;
    logic [9:0]       timer;
    logic [1:0][23:0] mem;
    logic             wrPtr;
    logic             rdPtr;
    logic [1:0]       count;
    logic             sdoSync1;
    logic             sdoSync2;
  } dasr_host_reg_t;

  localparam dasr_host_reg_t RESET_VALUE = '{
    st: HOST_IDLE, halfCnt: 4'h0, sclk: 1'b1, csN: 1'b1, bitCnt: 5'h00,
    shift: 32'h00000000, timer: 10'h000, mem: 48'h000000000000,
    wrPtr: 1'b0, rdPtr: 1'b0, count: 2'h0, sdoSync1: 1'b0, sdoSync2: 1'b0
  };

  dasr_host_reg_t q;
  dasr_host_reg_t next_q;
  logic           rise;
  logic           push;
  logic           pop;
  logic [31:0]    frame;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q          = q;
    next_q.sdoSync1 = link.sdo;
    next_q.sdoSync2 = q.sdoSync1;
    rise            = 1'b0;
    push            = 1'b0;
    pop             = (q.count != 2'h0) && resultReady;
    frame           = {q.shift[30:0], q.sdoSync2};
    // clock runs free so the converter sees the select go high
    if (q.halfCnt == 4'(HALF - 1)) begin
      next_q.halfCnt = 4'h0;
      next_q.sclk    = ~q.sclk;
      rise           = ~q.sclk;
    end else begin
      next_q.halfCnt = q.halfCnt + 4'h1;
    end
    if (q.timer != 10'h000) begin
      next_q.timer = q.timer - 10'h001;
    end
    if (rise) begin
      unique case (q.st)
        HOST_IDLE: begin
          // start only with room to store the result
          if (run && q.timer == 10'h000 && q.count != 2'h2) begin
            next_q.csN    = 1'b0; // RULE_09
            next_q.st     = HOST_FRAME;
            next_q.bitCnt = 5'h00;
            next_q.timer  = 10'(PER - 1); // RULE_11
          end
        end
        HOST_FRAME: begin
          next_q.shift  = frame; // RULE_07
          next_q.bitCnt = q.bitCnt + 5'h01;
          if (q.bitCnt == `DASR_LAST_BIT) begin
            push       = 1'b1;
            next_q.csN = 1'b1; // RULE_12
            next_q.st  = HOST_IDLE;
          end
        end
      endcase
    end
    if (push) begin
      next_q.mem[q.wrPtr] = {frame[27:16], frame[11:0]};
      next_q.wrPtr        = ~q.wrPtr;
    end
    if (pop) begin
      next_q.rdPtr = ~q.rdPtr;
    end
    next_q.count = q.count + {1'b0, push} - {1'b0, pop};
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RESET_VALUE;
    end else begin
      q <= next_q;
    end
  end

  assign link.sclk           = q.sclk;
  assign link.csN            = q.csN;
  assign resultValid         = (q.count != 2'h0);
  assign firstChannelResult  = q.mem[q.rdPtr][23:12];
  assign secondChannelResult = q.mem[q.rdPtr][11:0];

endmodule // dasr_host

// File: tb/dasr_link_chk.sv
// checker of the serial link between host end and converter end
// assumes sclk and csN are host registers clocked by clk
`timescale 1ns/100ps
module dasr_link_chk #(
  parameter int SCLK_HALF_CYC = 4,
  parameter int PERIOD_CYC    = 400
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic csN,
  input wire logic sdo
);
  logic       sclkQ;
  logic       seen;
  logic [3:0] halfCnt;
  logic [5:0] riseCnt;
  logic [9:0] gap;

  // ------
  // helper counters
  // ------
  // gap stays 0 until the first frame, so the first start is not judged
  always_ff @(posedge clk) begin
    sclkQ <= sclk;
    halfCnt <= (sclk != sclkQ) ? 4'h0 : halfCnt + 4'h1;
    seen <= !reset && (seen || sclk != sclkQ);
    riseCnt <= csN ? 6'h0 : riseCnt + 6'($rose(sclk));
    if (reset)
      gap <= 10'h0;
    else if ($fell(csN))
      gap <= 10'h1;
    else if (gap != 10'h0 && gap != 10'h3ff)
      gap <= gap + 10'h1;
  end

  // ------
  // properties
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_idle_sdo_low: assert property ($fell(sclk) && csN |-> !sdo)
    else $error("sdo not low at a fall with select high");
  a_idle_stays_quiet: assert property (csN && !sdo |=> !sdo)
    else $error("sdo moved while powered down");
  a_sdo_on_fall: assert property ($changed(sdo) |-> $fell(sclk))
    else $error("sdo changed away from a falling edge");
  a_select_on_rise: assert property ($changed(csN) |-> $rose(sclk))
    else $error("select moved away from a rising edge");
  a_frame_length: assert property ($rose(csN) |-> riseCnt == 6'h20)
    else $error("select low for other than 32 clocks");
  a_null_bits_zero: assert property ($rose(sclk) && !csN && (riseCnt inside {[1:4], [17:20]}) |-> !sdo)
    else $error("null bit not zero");
  a_sclk_half_period: assert property ((sclk != sclkQ) && seen |-> halfCnt == SCLK_HALF_CYC - 1)
    else $error("serial clock half period wrong");
  a_frame_spacing: assert property ($fell(csN) && gap != 10'h0 |-> gap >= PERIOD_CYC)
    else $error("frames closer than the sample period");

  c_frame: cover property ($rose(csN));
  c_back_to_back: cover property ($fell(csN) && gap != 10'h0 && gap < PERIOD_CYC + 16);
  c_data_one: cover property ($rose(sclk) && !csN && sdo);
endmodule // dasr_link_chk

// File: tb/dual_adc_serial_readout_tb_top.sv
// bench: host and converter ends joined, plus a converter end driven
// directly to break the select rule; assumes core files compiled first
`timescale 1ns/100ps
module dual_adc_serial_readout_tb_top
  import dasr_pkg::*;
();
  localparam int HALF   = 4;
  localparam int PERIOD = 400;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        run = 1'b0;
  logic        ready = 1'b0;
  logic        capEn = 1'b0;
  logic        valid, conv2, short2;
  logic [11:0] fPos, fNeg, sPos, sNeg;
  dasr_word_t  res1, res2, dev1, dev2, exp1, exp2;
  logic [31:0] frameBits;
  int          failures, checked, cycles, falls;

  dasr_link_if link ();
  dasr_link_if link2 ();

  dasr_host #(.SCLK_HALF_CYC(HALF), .PERIOD_CYC(PERIOD)) u_dasr_host (
    .clk(clk), .reset(reset), .link(link.host_end), .run(run), .resultValid(valid),
    .resultReady(ready), .firstChannelResult(res1), .secondChannelResult(res2));
  dasr_device u_dasr_device (
    .link(link.device_end), .firstChannelPosIn(fPos), .firstChannelNegIn(fNeg),
    .secondChannelPosIn(sPos), .secondChannelNegIn(sNeg), .converting(),
    .firstChannelResult(), .secondChannelResult(), .frameShort());
  dasr_device u_dasr_device_2 (
    .link(link2.device_end), .firstChannelPosIn(fPos), .firstChannelNegIn(fNeg),
    .secondChannelPosIn(sPos), .secondChannelNegIn(sNeg), .converting(conv2),
    .firstChannelResult(dev1), .secondChannelResult(dev2), .frameShort(short2));
  dasr_link_chk #(.SCLK_HALF_CYC(HALF), .PERIOD_CYC(PERIOD)) u_dasr_link_chk (
    .clk(clk), .reset(reset), .sclk(link.sclk), .csN(link.csN), .sdo(link.sdo));

  // ------
  // clock, watchdog and wire monitor
  // ------
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  // capture enable taken at the fall, since csN moves at the rise itself
  always @(negedge link.sclk) capEn <= !link.csN;
  always @(posedge link.sclk) if (capEn) frameBits <= {frameBits[30:0], link.sdo};
  always @(negedge link.csN) falls++;

  // ------
  // tasks
  // ------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (failures == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic pop();
    @(negedge clk);
    ready = 1'b1;
    @(negedge clk);
    ready = 1'b0;
  endtask
  task automatic waitValid();
    int n;
    n = 0;
    while (valid !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
  endtask
  // quiet the link, apply inputs, then take exactly one frame
  task automatic sample(input logic [47:0] v);
    logic [12:0] d1, d2;
    run = 1'b0;
    repeat (300) @(negedge clk);
    while (valid === 1'b1) pop();
    {fPos, fNeg, sPos, sNeg} = v;
    d1 = {1'b0, v[47:36]} - {1'b0, v[35:24]};
    d2 = {1'b0, v[23:12]} - {1'b0, v[11:0]};
    exp1 = d1[12:1];
    exp2 = d2[12:1];
    repeat (40) @(negedge clk);
    run = 1'b1;
    waitValid();
    run = 1'b0;
    check({31'h0, valid}, 32'h1);
    check({8'h0, res1, res2}, {8'h0, exp1, exp2});
    check(frameBits, {4'h0, exp1, 4'h0, exp2});
    pop();
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      #7.5 link2.sclk = 1'b0;
      #7.5 link2.sclk = 1'b1;
    end
  endtask

  initial begin
    link2.sclk = 1'b1;
    link2.csN = 1'b1;
    {fPos, fNeg, sPos, sNeg} = 48'h0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    sample(48'hfff_000_000_fff);
    sample(48'h800_800_123_456);
    sample(48'h000_002_a5a_5a5);
    sample(48'h7ff_800_fff_001);
    // stalled receiver: two frames fill the buffer, the third never starts
    repeat (300) @(negedge clk);
    falls = 0;
    run = 1'b1;
    repeat (2000) @(negedge clk);
    check(32'(falls), 32'h2);
    check({7'h0, valid, res1, res2}, {7'h0, 1'b1, exp1, exp2});
    ready = 1'b1;
    @(negedge clk);
    check({7'h0, valid, res1, res2}, {7'h0, 1'b1, exp1, exp2});
    @(negedge clk);
    ready = 1'b0;
    run = 1'b0;
    check({31'h0, valid}, 32'h0);
    // select raised mid-frame, then a whole frame
    pulses(2);
    link2.csN = 1'b0;
    pulses(10);
    check({31'h0, conv2}, 32'h1);
    link2.csN = 1'b1;
    pulses(1);
    check({29'h0, conv2, short2, link2.sdo}, 32'h2);
    link2.csN = 1'b0;
    pulses(16);
    check({20'h0, dev1}, {20'h0, exp1});
    pulses(16);
    link2.csN = 1'b1;
    pulses(1);
    check({7'h0, short2, dev1, dev2}, {8'h0, exp1, exp2});
    stop_test();
  end
endmodule // dual_adc_serial_readout_tb_top
